// File: aptc_asserts.sv
// Purpose: port checks for the pair trigger block
// Assumes: one clock, sync reset
// Notes: bound into every aptc_top
`timescale 1ns/1ns
module aptc_asserts #(
  parameter int CONV_CYCLES = aptc_pkg::CONV_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_special,
  input wire logic [2:0] i_pwm_pri,
  input wire logic [2:0] i_pwm_sec,
  input wire logic [2:0] i_pwm_lim,
  input wire logic [1:0] i_tmr,
  input wire logic [7:0] o_pin_digital,
  input wire logic [7:0] o_mux_to_ground,
  input wire logic [3:0] o_pair_done_irq,
  input wire logic o_busy,
  input wire logic [1:0] o_conv_pair
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  logic [15:0] wd_q;
  int run_len;
  // run length lets a short busy show without a long repetition
  always_ff @(posedge i_sys_clk)
  begin
    wd_q <= i_wdata;
    run_len <= o_busy ? run_len + 1 : 0;
  end
  pin_map_a: assert property (o_pin_digital == o_mux_to_ground && o_pin_digital[5:4] == 2'h0)
    else $error("pin outputs disagree");
  pin_write_a: assert property (i_wr && i_addr == aptc_pkg::ADDR_PINCFG |=>
    o_pin_digital == (wd_q[7:0] & 8'hcf)) else $error("pin config not applied");
  ready_bits_a: assert property (i_rd && i_addr == aptc_pkg::ADDR_READY |=>
    o_rdata[15:4] == 12'h000) else $error("unimplemented ready bit set");
  base_bit0_a: assert property (i_rd && i_addr == aptc_pkg::ADDR_BASE |=> !o_rdata[0])
    else $error("base bit 0 set");
  ctrl_keep_a: assert property ((i_wr && i_addr == aptc_pkg::ADDR_CTRL_LOW) ##1
    (i_rd && i_addr == aptc_pkg::ADDR_CTRL_LOW) |=> (o_rdata & 16'h1f1f) == ($past(wd_q) & 16'h1f1f))
    else $error("source field lost");
  irq_busy_a: assert property (|o_pair_done_irq |-> o_busy || $past(o_busy))
    else $error("irq without conversion");
  conv_len_a: assert property ($fell(o_busy) |-> run_len >= CONV_CYCLES)
    else $error("conversion too short");
  irq_single_a: assert property ($onehot0(o_pair_done_irq))
    else $error("two pairs done at once");
  irq_pair_a: assert property (|o_pair_done_irq |-> o_pair_done_irq == (4'h1 << o_conv_pair))
    else $error("irq from a pair not converting");
  pair_hold_a: assert property (o_busy && $past(o_busy) |-> $stable(o_conv_pair))
    else $error("pair changed mid conversion");
  cover property (o_pair_done_irq == 4'h2);
  cover property (o_pair_done_irq == 4'h8);
  cover property (i_rd && i_addr == aptc_pkg::ADDR_BASE);
  cover property ($fell(o_busy));
endmodule : aptc_asserts

bind aptc_top aptc_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.i_sys_clk, .i_srst, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_special, .i_pwm_pri, .i_pwm_sec, .i_pwm_lim, .i_tmr,
  .o_pin_digital, .o_mux_to_ground, .o_pair_done_irq, .o_busy, .o_conv_pair);

// File: aptc_pkg.sv
// Purpose: constants for the converter pair trigger and status block
// Assumes: 16-bit register port, one system clock at 100 MHz
// Notes: register offsets are word indices on the plain register port
// Function
// - data-ready flag sets when pair result is buffered, cleared by writing zero
// - status register holds flags for pairs 0,1,2,3,6 only; others read zero; no pair 6 is built here, so bit 6 always reads zero
// - base register keeps written bits 15..1; bit 0 reads zero
// - base register read returns stored base plus encoded ready-flag number
// - encoder gives lowest-numbered set ready flag; pair 0 wins
// - encoded number shifted left two before the add
// - config bit one: pin digital, read input on, mux to ground
// - config bit zero: pin analog, read input off, pin sampled
// - irq enable set raises pair interrupt on conversion completion
// - pending sets on selected trigger, clears at conversion completion
// - individual soft kick starts pair only when source selects it
// - soft kick bit cleared by hardware as pending sets
// - codes 1,2,3 select individual soft, global soft, special event
// - codes 4,5,7 select pwm 1,2,4 primary; 6 reserved
// - codes 14,15,17 select pwm 1,2,4 secondary; 16 reserved
// - codes 23,24,26 select pwm 1,2,4 current limit; 25 reserved
// - code 12 timer one, code 31 timer two; 27..30 reserved
// - control low: upper byte pair 1, lower byte pair 0
// - triggered pair waits pending until the converter is free
// - global soft kick not self-clearing; triggers every pair selecting it
// - simultaneous requests converted in order from lowest pair
package aptc_pkg;
  localparam logic [2:0] ADDR_READY = 3'h0;
  localparam logic [2:0] ADDR_BASE = 3'h1;
  localparam logic [2:0] ADDR_PINCFG = 3'h2;
  localparam logic [2:0] ADDR_CTRL_LOW = 3'h3;
  localparam logic [2:0] ADDR_CTRL_HIGH = 3'h4;
  localparam logic [2:0] ADDR_GLOBAL = 3'h5;
  localparam logic [15:0] READY_MASK = 16'h004f;
  localparam logic [15:0] BASE_MASK = 16'hfffe;
  localparam logic [15:0] PINCFG_MASK = 16'h00cf;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam int GLOBAL_BIT = 10;
  localparam int ENC_SHIFT = 2;
  localparam int IRQ_BIT = 7;
  localparam int PEND_BIT = 6;
  localparam int KICK_BIT = 5;
  localparam int SRC_MSB = 4;
  localparam int NUM_PAIRS = 7;
  localparam logic [4:0] SRC_SOFT = 5'h01;
  localparam logic [4:0] SRC_GLOBAL = 5'h02;
  localparam logic [4:0] SRC_SPECIAL = 5'h03;
  localparam logic [4:0] SRC_PWM1_PRI = 5'h04;
  localparam logic [4:0] SRC_PWM2_PRI = 5'h05;
  localparam logic [4:0] SRC_PWM4_PRI = 5'h07;
  localparam logic [4:0] SRC_TMR1 = 5'h0c;
  localparam logic [4:0] SRC_PWM1_SEC = 5'h0e;
  localparam logic [4:0] SRC_PWM2_SEC = 5'h0f;
  localparam logic [4:0] SRC_PWM4_SEC = 5'h11;
  localparam logic [4:0] SRC_PWM1_LIM = 5'h17;
  localparam logic [4:0] SRC_PWM2_LIM = 5'h18;
  localparam logic [4:0] SRC_PWM4_LIM = 5'h1a;
  localparam logic [4:0] SRC_TMR2 = 5'h1f;
  localparam int CONV_NS = 500;
  localparam int CLK_NS = 10;
  localparam int CONV_CYCLES = CONV_NS / CLK_NS;
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT} aptc_state_t;
endpackage : aptc_pkg

// File: aptc_top.sv
// Purpose: pair trigger, pending, ready, jump-table base and pin config
// Assumes: trigger strobes come from logic on the same clock
// Notes: the conversion itself is modelled as a fixed busy time
`timescale 1ns/1ns
module aptc_top #(
  parameter int CONV_CYCLES = aptc_pkg::CONV_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_special,
  input wire logic [2:0] i_pwm_pri,
  input wire logic [2:0] i_pwm_sec,
  input wire logic [2:0] i_pwm_lim,
  input wire logic [1:0] i_tmr,
  output logic [7:0] o_pin_digital,
  output logic [7:0] o_mux_to_ground,
  output logic [3:0] o_pair_done_irq,
  output logic o_busy,
  output logic [1:0] o_conv_pair
);
  localparam int NP = 4;
  logic [NP-1:0] irq_en;
  logic [NP-1:0] pend;
  logic [NP-1:0] kick;
  logic [4:0] src [NP];
  logic [NP-1:0] trig;
  logic [NP-1:0] ready;
  logic [NP-1:0] done;
  logic global_kick;
  logic global_kick_q;
  logic global_pulse;
  logic [15:0] base;
  logic [15:0] pincfg;
  logic [15:0] ready_word;
  logic [15:0] ctrl_low;
  logic [15:0] ctrl_high;
  logic [15:0] enc;
  logic [2:0] enc_num;
  aptc_pkg::aptc_state_t state;
  logic [15:0] cnt;
  logic [1:0] cur;
  logic [1:0] next_cur;
  logic have_req;
  logic wr_low;
  logic wr_high;

  // pairs 0..3 map to status bits 0..3; pair 6 slot exists but has no channels here
  assign ready_word = {12'h000, ready} & aptc_pkg::READY_MASK;
  assign wr_low = i_wr && (i_addr == aptc_pkg::ADDR_CTRL_LOW);
  assign wr_high = i_wr && (i_addr == aptc_pkg::ADDR_CTRL_HIGH);

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_pair
      localparam int SH = (g % 2) * 8;
      logic wr_ctrl;
      logic [7:0] wbyte;
      assign wr_ctrl = (g < 2) ? wr_low : wr_high;
      assign wbyte = i_wdata[SH +: 8];

      aptc_trig_sel u_sel (
        .i_sel(src[g]),
        .i_soft(kick[g]),
        .i_global(global_pulse),
        .i_special(i_special),
        .i_pwm_pri(i_pwm_pri),
        .i_pwm_sec(i_pwm_sec),
        .i_pwm_lim(i_pwm_lim),
        .i_tmr(i_tmr),
        .o_trig(trig[g])
      );

      always_ff @(posedge i_sys_clk)
      begin
        if (i_srst)
        begin
          irq_en[g] <= 1'b0;
          src[g] <= 5'h00;
        end
        else if (wr_ctrl)
        begin
          irq_en[g] <= wbyte[aptc_pkg::IRQ_BIT];
          src[g] <= wbyte[aptc_pkg::SRC_MSB:0];
        end
      end

      // trigger wins over a conversion completion (done) of the same cycle
      always_ff @(posedge i_sys_clk)
      begin
        if (i_srst)
          pend[g] <= 1'b0;
        else if (trig[g])
          pend[g] <= 1'b1;
        else if (done[g])
          pend[g] <= 1'b0;
      end

      always_ff @(posedge i_sys_clk)
      begin
        if (i_srst)
          kick[g] <= 1'b0;
        else if (trig[g] && src[g] == aptc_pkg::SRC_SOFT)
          kick[g] <= 1'b0;
        // a plain write lets software withdraw a kick that never fired
        else if (wr_ctrl)
          kick[g] <= wbyte[aptc_pkg::KICK_BIT];
      end

      always_ff @(posedge i_sys_clk)
      begin
        if (i_srst)
          ready[g] <= 1'b0;
        else if (done[g])
          ready[g] <= 1'b1;
        else if (i_wr && i_addr == aptc_pkg::ADDR_READY && !i_wdata[g])
          ready[g] <= 1'b0;
      end

      assign done[g] = (state == aptc_pkg::ST_CONVERT) && (cnt == 16'h0000) && (cur == 2'(g));
      assign o_pair_done_irq[g] = done[g] && irq_en[g];
      assign o_pin_digital[2*g] = pincfg[2*g];
      assign o_pin_digital[2*g+1] = pincfg[2*g+1];
      assign o_mux_to_ground[2*g] = pincfg[2*g];
      assign o_mux_to_ground[2*g+1] = pincfg[2*g+1];
    end
  endgenerate

  // lowest pending pair converts first
  always_comb
  begin
    have_req = 1'b0;
    next_cur = 2'h0;
    for (int i = NP - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        have_req = 1'b1;
        next_cur = 2'(i);
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      state <= aptc_pkg::ST_IDLE;
      cnt <= 16'h0000;
      cur <= 2'h0;
    end
    else
    begin
      case (state)
        aptc_pkg::ST_IDLE:
        begin
          if (have_req)
          begin
            state <= aptc_pkg::ST_CONVERT;
            cur <= next_cur;
            cnt <= 16'(CONV_CYCLES - 1);
          end
        end
        aptc_pkg::ST_CONVERT:
        begin
          if (cnt == 16'h0000)
            state <= aptc_pkg::ST_IDLE;
          else
            cnt <= cnt - 16'h0001;
        end
        default: state <= aptc_pkg::ST_IDLE;
      endcase
    end
  end
  assign o_busy = (state == aptc_pkg::ST_CONVERT);
  assign o_conv_pair = cur;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      global_kick <= 1'b0;
    else if (i_wr && i_addr == aptc_pkg::ADDR_GLOBAL)
      global_kick <= i_wdata[aptc_pkg::GLOBAL_BIT];
  end

  // one trigger per setting; a bit left set must not keep re-arming pairs
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      global_kick_q <= 1'b0;
    else
      global_kick_q <= global_kick;
  end
  assign global_pulse = global_kick && !global_kick_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      base <= aptc_pkg::RESET_VALUE;
    else if (i_wr && i_addr == aptc_pkg::ADDR_BASE)
      base <= i_wdata & aptc_pkg::BASE_MASK;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      pincfg <= aptc_pkg::RESET_VALUE;
    else if (i_wr && i_addr == aptc_pkg::ADDR_PINCFG)
      pincfg <= i_wdata & aptc_pkg::PINCFG_MASK;
  end

  // bit number of highest priority ready flag; zero if none set
  always_comb
  begin
    enc_num = 3'h0;
    for (int i = aptc_pkg::NUM_PAIRS - 1; i >= 0; i--)
    begin
      if (ready_word[i])
        enc_num = 3'(i);
    end
  end
  assign enc = {13'h0000, enc_num} << aptc_pkg::ENC_SHIFT;

  assign ctrl_low = {irq_en[1], pend[1], kick[1], src[1], irq_en[0], pend[0], kick[0], src[0]};
  assign ctrl_high = {irq_en[3], pend[3], kick[3], src[3], irq_en[2], pend[2], kick[2], src[2]};

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_rdata <= 16'h0000;
    else if (i_rd)
    begin
      case (i_addr)
        aptc_pkg::ADDR_READY: o_rdata <= ready_word;
        aptc_pkg::ADDR_BASE: o_rdata <= base + enc;
        aptc_pkg::ADDR_PINCFG: o_rdata <= pincfg;
        aptc_pkg::ADDR_CTRL_LOW: o_rdata <= ctrl_low;
        aptc_pkg::ADDR_CTRL_HIGH: o_rdata <= ctrl_high;
        aptc_pkg::ADDR_GLOBAL: o_rdata <= 16'(global_kick) << aptc_pkg::GLOBAL_BIT;
        default: o_rdata <= 16'h0000;
      endcase
    end
    else
      o_rdata <= 16'h0000;
  end
endmodule : aptc_top

// File: aptc_trig_sel.sv
// Purpose: decodes one pair's five-bit source code into a trigger strobe
// Assumes: all strobes are one-cycle pulses on the system clock
// Notes: unlisted codes give no trigger
`timescale 1ns/1ns
module aptc_trig_sel (
  input wire logic [4:0] i_sel,
  input wire logic i_soft,
  input wire logic i_global,
  input wire logic i_special,
  input wire logic [2:0] i_pwm_pri,
  input wire logic [2:0] i_pwm_sec,
  input wire logic [2:0] i_pwm_lim,
  input wire logic [1:0] i_tmr,
  output logic o_trig
);
  always_comb
  begin
    case (i_sel)
      aptc_pkg::SRC_SOFT: o_trig = i_soft;
      aptc_pkg::SRC_GLOBAL: o_trig = i_global;
      aptc_pkg::SRC_SPECIAL: o_trig = i_special;
      aptc_pkg::SRC_PWM1_PRI: o_trig = i_pwm_pri[0];
      aptc_pkg::SRC_PWM2_PRI: o_trig = i_pwm_pri[1];
      aptc_pkg::SRC_PWM4_PRI: o_trig = i_pwm_pri[2];
      aptc_pkg::SRC_PWM1_SEC: o_trig = i_pwm_sec[0];
      aptc_pkg::SRC_PWM2_SEC: o_trig = i_pwm_sec[1];
      aptc_pkg::SRC_PWM4_SEC: o_trig = i_pwm_sec[2];
      aptc_pkg::SRC_PWM1_LIM: o_trig = i_pwm_lim[0];
      aptc_pkg::SRC_PWM2_LIM: o_trig = i_pwm_lim[1];
      aptc_pkg::SRC_PWM4_LIM: o_trig = i_pwm_lim[2];
      aptc_pkg::SRC_TMR1: o_trig = i_tmr[0];
      aptc_pkg::SRC_TMR2: o_trig = i_tmr[1];
      default: o_trig = 1'b0;
    endcase
  end
endmodule : aptc_trig_sel

// File: aptc_trig_src.sv
// Purpose: pwm and timer strobe source model
// Assumes: strobes are one-cycle pulses on the system clock
// Notes: line 0 special, 1-3 primary, 4-6 secondary, 7-9 limit, 10-11 timers
`timescale 1ns/1ns
module aptc_trig_src (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_line,
  output logic [11:0] o_strobe
);
  always_ff @(posedge i_clk)
    o_strobe <= i_go ? (12'h001 << i_line) : 12'h000;
endmodule : aptc_trig_src

// File: tb_top.sv
// Purpose: self-checking bench for aptc_top
// Assumes: CONV_CYCLES shortened to 2
// Notes: read results checked by a queue watcher
`timescale 1ns/1ns
module tb_top;
  logic i_sys_clk = 0;
  logic i_srst = 1;
  logic [2:0] i_addr = 0;
  logic [15:0] i_wdata = 0;
  logic i_wr = 0;
  logic i_rd = 0;
  logic go = 0;
  logic [3:0] line = 0;
  logic [11:0] strobe;
  logic [15:0] o_rdata;
  logic [7:0] pin_dig;
  logic [7:0] pin_gnd;
  logic [3:0] irq;
  logic busy;
  logic [1:0] cpair;
  logic rd_d = 0;
  logic irq_seen = 0;
  logic [15:0] exp_q[$];
  logic [15:0] d;
  logic [15:0] b;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'h5151;
  logic [4:0] codes [12] = '{5'h03, 5'h04, 5'h05, 5'h07, 5'h0e, 5'h0f, 5'h11, 5'h17, 5'h18,
    5'h1a, 5'h0c, 5'h1f};
  logic [4:0] resv [5] = '{5'h00, 5'h06, 5'h10, 5'h19, 5'h1b};
  always #5 i_sys_clk = ~i_sys_clk;
  aptc_top #(.CONV_CYCLES(2)) dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_special(strobe[0]),
    .i_pwm_pri(strobe[3:1]), .i_pwm_sec(strobe[6:4]), .i_pwm_lim(strobe[9:7]),
    .i_tmr(strobe[11:10]), .o_pin_digital(pin_dig), .o_mux_to_ground(pin_gnd),
    .o_pair_done_irq(irq), .o_busy(busy), .o_conv_pair(cpair));
  aptc_trig_src u_src (.i_clk(i_sys_clk), .i_go(go), .i_line(line), .o_strobe(strobe));
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    checks_done++;
    if (got !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk
  // reads carry their expected value in v
  task automatic op(input logic w, input logic [2:0] a, input logic [15:0] v);
    @(posedge i_sys_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= v;
    if (!w)
      exp_q.push_back(v);
  endtask : op
  task automatic idle;
    @(posedge i_sys_clk);
    i_wr <= 0;
    i_rd <= 0;
  endtask : idle
  task automatic fire(input logic [3:0] l);
    @(posedge i_sys_clk);
    go <= 1;
    line <= l;
    @(posedge i_sys_clk);
    go <= 0;
  endtask : fire
  task automatic wait_irq(input logic [3:0] e);
    int n;
    n = 0;
    while (irq === 4'h0 && n < 40)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n == 40)
    begin
      errors++;
      give_verdict();
    end
    else
    begin
      chk({12'h000, irq}, {12'h000, e});
      chk({12'h000, 4'h1 << cpair}, {12'h000, e});
      chk({15'h0000, busy}, 16'h0001);
      @(posedge i_sys_clk);
    end
  endtask : wait_irq
  always @(posedge i_sys_clk)
  begin
    if (rd_d)
      chk(o_rdata, exp_q.pop_front());
    rd_d <= i_rd;
    if (|irq)
      irq_seen <= 1;
  end
  initial
  begin
    repeat (6) @(posedge i_sys_clk);
    i_srst <= 0;
    for (int a = 0; a < 8; a++)
      op(0, a[2:0], 16'h0000);
    repeat (2)
    begin
      d = $random(seed);
      op(1, aptc_pkg::ADDR_PINCFG, d);
      op(0, aptc_pkg::ADDR_PINCFG, d & aptc_pkg::PINCFG_MASK);
      idle();
      chk({8'h00, pin_dig}, d & aptc_pkg::PINCFG_MASK);
      chk({8'h00, pin_gnd}, d & aptc_pkg::PINCFG_MASK);
    end
    b = $random(seed);
    op(1, aptc_pkg::ADDR_BASE, b);
    op(0, aptc_pkg::ADDR_BASE, b & aptc_pkg::BASE_MASK);
    for (int k = 0; k < 12; k++)
    begin
      op(1, aptc_pkg::ADDR_CTRL_LOW, {8'h00, 3'h4, codes[k]});
      idle();
      fire(k[3:0]);
      wait_irq(4'h1);
      op(0, aptc_pkg::ADDR_READY, 16'h0001);
      op(1, aptc_pkg::ADDR_READY, 16'h0001);
      op(0, aptc_pkg::ADDR_READY, 16'h0001);
      op(1, aptc_pkg::ADDR_READY, 16'h0000);
      op(0, aptc_pkg::ADDR_CTRL_LOW, {8'h00, 3'h4, codes[k]});
      op(0, aptc_pkg::ADDR_READY, 16'h0000);
      idle();
    end
    for (int k = 0; k < 6; k++)
    begin
      // last pass: soft kick while a pwm source is selected
      op(1, aptc_pkg::ADDR_CTRL_LOW, k < 5 ? {8'h00, 3'h4, resv[k]} : 16'h00a4);
      idle();
      irq_seen <= 0;
      for (int j = 0; j < 12 && k < 5; j++)
        fire(j[3:0]);
      repeat (6) @(posedge i_sys_clk);
      chk({15'h0000, irq_seen}, 16'h0000);
    end
    op(1, aptc_pkg::ADDR_CTRL_LOW, 16'h0081);
    op(1, aptc_pkg::ADDR_CTRL_LOW, 16'h00a1);
    idle();
    wait_irq(4'h1);
    op(0, aptc_pkg::ADDR_CTRL_LOW, 16'h0081);
    op(1, aptc_pkg::ADDR_READY, 16'h0000);
    op(1, aptc_pkg::ADDR_CTRL_LOW, 16'h8282);
    op(0, aptc_pkg::ADDR_CTRL_LOW, 16'h8282);
    op(1, aptc_pkg::ADDR_CTRL_HIGH, 16'h8282);
    op(0, aptc_pkg::ADDR_CTRL_HIGH, 16'h8282);
    op(1, aptc_pkg::ADDR_GLOBAL, 16'h0400);
    op(1, aptc_pkg::ADDR_GLOBAL, 16'h0000);
    idle();
    wait_irq(4'h1);
    wait_irq(4'h2);
    wait_irq(4'h4);
    wait_irq(4'h8);
    op(0, aptc_pkg::ADDR_READY, 16'h000f);
    op(0, aptc_pkg::ADDR_BASE, b & aptc_pkg::BASE_MASK);
    op(1, aptc_pkg::ADDR_READY, 16'h000c);
    op(0, aptc_pkg::ADDR_BASE, (b & aptc_pkg::BASE_MASK) + 16'h0008);
    op(1, aptc_pkg::ADDR_READY, 16'h0008);
    op(0, aptc_pkg::ADDR_BASE, (b & aptc_pkg::BASE_MASK) + 16'h000c);
    op(0, aptc_pkg::ADDR_READY, 16'h0008);
    op(0, aptc_pkg::ADDR_CTRL_HIGH, 16'h8282);
    idle();
    repeat (2) @(posedge i_sys_clk);
    give_verdict();
  end
endmodule : tb_top
